// File: verilog/reset_source_pkg.sv
package reset_source_pkg;

    // Register byte addresses
    localparam logic [7:0] guard_code_addr   = 8'h00;
    localparam logic [7:0] cause_flags_addr  = 8'h04;
    localparam logic [7:0] level_select_addr = 8'h08;
    localparam logic [7:0] control_addr      = 8'h0c;
    localparam logic [7:0] status_addr       = 8'h10;

    // Reset values and valid codes
    localparam logic [7:0] guard_code_por    = 8'h55;
    localparam logic [7:0] guard_code_alt    = 8'haa;
    localparam logic [7:0] level_code_por    = 8'h55;
    localparam logic [7:0] level_code_2v55   = 8'h33;
    localparam logic [7:0] level_code_3v15   = 8'h99;
    localparam logic [7:0] level_code_3v80   = 8'haa;

    // Cause flag positions
    localparam int watchdog_flag_bit     = 0;
    localparam int level_code_flag_bit   = 1;
    localparam int undervoltage_flag_bit = 2;
    localparam int guard_flag_bit        = 3;
    localparam int cause_flag_width      = 4;

    // Status and control bit positions
    localparam int status_reset_bit      = 0;
    localparam int status_delay_bit      = 1;
    localparam int control_powerdown_bit = 0;

    // Timing
    localparam int clock_mhz             = 200;
    localparam int power_on_delay_ms     = 50;
    localparam int power_on_delay_cycles = power_on_delay_ms * clock_mhz
                                           * 1000;
    localparam int code_fault_min_edges  = 3;
    localparam int sync_stages           = 3;

    // Undervoltage level selection
    typedef enum logic [1:0] {
        level_2v10 = 2'b00,
        level_2v55 = 2'b01,
        level_3v15 = 2'b11,
        level_3v80 = 2'b10
    } level_sel_t;

    // Reset sources gathered together
    typedef struct packed {
        logic guard_fault;
        logic undervoltage;
        logic level_fault;
        logic watchdog_fault;
    } reset_sources_t;

endpackage

// File: verilog/pin_synchroniser.sv
`timescale 1ns/100ps
module pin_synchroniser #(
    parameter logic reset_level = 1'b0
) (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Pin and filtered level
    input  wire logic pin_in,
    output logic      level_out,
    output logic      rise_pulse
);

    logic [2:0] stage_reg;
    logic       level_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage_reg <= {3{reset_level}};
        end else begin
            stage_reg <= {stage_reg[1:0], pin_in};
        end
    end

    // Change counts once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_reg <= reset_level;
        end else if (stage_reg[1] == stage_reg[2]) begin
            level_reg <= stage_reg[2];
        end
    end

    assign level_out  = level_reg;
    assign rise_pulse = (stage_reg[1] == stage_reg[2]) && stage_reg[2]
                        && !level_reg;

endmodule

// File: verilog/code_fault_timer.sv
`timescale 1ns/100ps
module code_fault_timer #(
    parameter int min_edges = 2
) (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Fault condition and slow clock edge
    input  wire logic fault,
    input  wire logic slow_edge,
    output logic      fire
);

    initial begin
        if (min_edges < 1 || min_edges > 3) begin
            $error("code_fault_timer: min_edges out of range");
        end
    end

    logic [1:0] edges_reg;

    // Counts slow clock edges while the code stays invalid
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edges_reg <= 2'h0;
        end else if (!fault) begin
            edges_reg <= 2'h0;
        end else if (slow_edge && edges_reg != 2'(min_edges)) begin
            edges_reg <= edges_reg + 2'h1;
        end
    end

    assign fire = fault && (edges_reg == 2'(min_edges));

endmodule

// File: verilog/reset_source_control.sv
`timescale 1ns/100ps
// Functional notes
// [RULE1] Invalid guard code resets after 2-3 slow periods
// [RULE2] Guard code powers up as 0x55
// [RULE3] Guard fault sets cause bit 3
// [RULE4] Guard flag sticky, software zero clears
// [RULE5] Cause bits 7..4 read zero
// [RULE6] Qualified low supply resets, sets bit 2
// [RULE7] Short low-supply pulses are ignored
// [RULE8] Undervoltage always active, no enable; code masks it while powerdown_reg is set
// [RULE9] Threshold code selects four voltage levels
// [RULE10] Invalid threshold code resets, sets bit 1
// [RULE11] Threshold fault restores threshold to 0x55
// [RULE12] Genuine undervoltage keeps threshold contents
// [RULE13] Threshold code powers up as 0x55
// [RULE14] Undervoltage disabled in power-down
// [RULE15] Power-on clears program counter
// [RULE16] Port registers power up all ones
// [RULE17] Hold reset for power-on delay
// [RULE18] Watchdog code fault sets bit 0
// [RULE19] Threshold flag cleared only by software zero
// [RULE20] Sources merged, flags survive other resets
module reset_source_control #(
    parameter int power_on_delay_cycles =
        reset_source_pkg::power_on_delay_cycles,
    parameter int pc_width   = 13,
    parameter int port_width = 8
) (
    // Bus clock and power-on reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [7:0]            haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // Analog and neighbouring sources
    input  wire logic                  slow_rc_clock,
    input  wire logic                  low_supply,
    input  wire logic                  low_supply_qualified,
    input  wire logic                  watchdog_code_fault,
    // Reset outputs
    output logic                       system_reset,
    output logic [1:0]                 undervoltage_level,
    output logic [pc_width-1:0]        pc_reset_value,
    output logic [port_width-1:0]      port_data_reset_value,
    output logic [port_width-1:0]      port_control_reset_value
);

    // Elaboration checks
    initial begin
        if (power_on_delay_cycles < 1) begin
            $error("power_on_delay_cycles must be at least one");
        end
        if (pc_width < 1 || port_width < 1) begin
            $error("pc_width and port_width must be positive");
        end
        if (reset_source_pkg::cause_flag_width != 4) begin
            $error("cause flag field must be four bits wide");
        end
    end

    typedef enum logic [1:0] {
        st_hold  = 2'b00,
        st_delay = 2'b01,
        st_run   = 2'b11
    } seq_state_t;

    // Synchronised inputs
    logic slow_level;
    logic slow_edge;
    logic low_level;
    logic qual_level;
    logic wd_level;

    pin_synchroniser #(.reset_level(1'b0)) u_sync_slow (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pin_in     (slow_rc_clock),
        .level_out  (slow_level),
        .rise_pulse (slow_edge)
    );

    pin_synchroniser #(.reset_level(1'b0)) u_sync_low (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pin_in     (low_supply),
        .level_out  (low_level),
        .rise_pulse ()
    );

    pin_synchroniser #(.reset_level(1'b0)) u_sync_qual (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pin_in     (low_supply_qualified),
        .level_out  (qual_level),
        .rise_pulse ()
    );

    pin_synchroniser #(.reset_level(1'b0)) u_sync_wd (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pin_in     (watchdog_code_fault),
        .level_out  (wd_level),
        .rise_pulse ()
    );

    // Registers
    logic [7:0]                          guard_code_reg;
    logic [7:0]                          level_code_reg;
    logic [reset_source_pkg::cause_flag_width-1:0] flags_reg;
    logic                                powerdown_reg;
    seq_state_t                          state_reg;
    logic [31:0]                         delay_reg;

    // Bus address phase capture
    logic       wr_pend_reg;
    logic [7:0] addr_reg;
    logic       rd_pend_reg;

    logic                              access;
    logic                              wr_guard;
    logic                              wr_level;
    logic                              wr_flags;
    logic                              wr_ctrl;
    reset_source_pkg::reset_sources_t  src;
    logic                              guard_fault;
    logic                              level_fault;
    logic                              guard_fire;
    logic                              level_fire;
    logic                              uv_trigger;
    logic                              any_source;

    assign access   = hsel && hready && htrans[1];
    assign wr_guard = wr_pend_reg
                      && addr_reg == reset_source_pkg::guard_code_addr;
    assign wr_level = wr_pend_reg
                      && addr_reg == reset_source_pkg::level_select_addr;
    assign wr_flags = wr_pend_reg
                      && addr_reg == reset_source_pkg::cause_flags_addr;
    assign wr_ctrl  = wr_pend_reg
                      && addr_reg == reset_source_pkg::control_addr;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end else begin
            wr_pend_reg <= access && hwrite;
            rd_pend_reg <= access && !hwrite;
            if (access) begin
                addr_reg <= {haddr[7:2], 2'b00};
            end
        end
    end

    // Code checks
    assign guard_fault = guard_code_reg != reset_source_pkg::guard_code_por
                      && guard_code_reg != reset_source_pkg::guard_code_alt;
    assign level_fault =
        !(level_code_reg == reset_source_pkg::level_code_por
       || level_code_reg == reset_source_pkg::level_code_2v55
       || level_code_reg == reset_source_pkg::level_code_3v15
       || level_code_reg == reset_source_pkg::level_code_3v80);

    code_fault_timer #(
        .min_edges(reset_source_pkg::code_fault_min_edges)
    ) u_guard_timer (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .fault     (guard_fault),
        .slow_edge (slow_edge),
        .fire      (guard_fire)
    ); // [RULE1]

    code_fault_timer #(
        .min_edges(reset_source_pkg::code_fault_min_edges)
    ) u_level_timer (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .fault     (level_fault),
        .slow_edge (slow_edge),
        .fire      (level_fire)
    ); // [RULE10]

    // Qualified low supply only, not in power-down, no enable bit
    assign uv_trigger = low_level && qual_level // [RULE7] [RULE8]
                        && !powerdown_reg;      // [RULE14]

    assign src.guard_fault    = guard_fire; // [RULE3]
    assign src.undervoltage   = uv_trigger; // [RULE6]
    assign src.level_fault    = level_fire;
    assign src.watchdog_fault = wd_level; // [RULE18]
    assign any_source = |src; // [RULE20]

    // Guard code register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            guard_code_reg <= reset_source_pkg::guard_code_por; // [RULE2]
        end else if (wr_guard) begin
            guard_code_reg <= hwdata[7:0];
        end else if (guard_fire) begin
            guard_code_reg <= reset_source_pkg::guard_code_por;
        end
    end

    // Threshold code register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_code_reg <= reset_source_pkg::level_code_por; // [RULE13]
        end else if (level_fire) begin
            level_code_reg <= reset_source_pkg::level_code_por; // [RULE11]
        end else if (wr_level && state_reg == st_run) begin
            level_code_reg <= hwdata[7:0];
        end
        // Undervoltage reset leaves it untouched [RULE12]
    end

    // Cause flags: set wins over software clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_reg <= '0;
        end else begin
            for (int i = 0; i < reset_source_pkg::cause_flag_width; i++) begin
                if (src[i]) begin
                    flags_reg[i] <= 1'b1;
                end else if (wr_flags && !hwdata[i]) begin
                    flags_reg[i] <= 1'b0; // [RULE4] [RULE19]
                end
            end
        end
    end
    // Bit order of src matches 3 guard, 2 uv, 1 level, 0 watchdog

    // Power-down control
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            powerdown_reg <= 1'b0;
        end else if (wr_ctrl) begin
            powerdown_reg <=
                hwdata[reset_source_pkg::control_powerdown_bit]; // [RULE14]
        end
    end

    // Last cycle of the power-on delay
    logic delay_done;
    assign delay_done = delay_reg == 32'(power_on_delay_cycles - 1);

    // Reset sequencer with power-on delay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= st_delay;
            delay_reg <= 32'h0;
        end else if (any_source) begin
            state_reg <= st_hold;
            delay_reg <= 32'h0;
        end else begin
            case (state_reg)
                st_hold: begin
                    state_reg <= st_delay;
                    delay_reg <= 32'h0;
                end
                st_delay: begin
                    if (delay_done) begin
                        state_reg <= st_run; // [RULE17]
                    end else begin
                        delay_reg <= delay_reg + 32'h1;
                    end
                end
                st_run: begin
                    state_reg <= st_run;
                end
                default: begin
                    state_reg <= st_hold;
                end
            endcase
        end
    end

    assign system_reset = state_reg != st_run;

    // Level decode for the analog comparator [RULE9]
    logic [1:0] level_sel_next;

    always_comb begin
        case (level_code_reg)
            reset_source_pkg::level_code_2v55:
                level_sel_next = reset_source_pkg::level_2v55;
            reset_source_pkg::level_code_3v15:
                level_sel_next = reset_source_pkg::level_3v15;
            reset_source_pkg::level_code_3v80:
                level_sel_next = reset_source_pkg::level_3v80;
            default:
                level_sel_next = reset_source_pkg::level_2v10;
        endcase
    end

    // Registered level select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            undervoltage_level <= reset_source_pkg::level_2v10;
        end else begin
            undervoltage_level <= level_sel_next; // [RULE9]
        end
    end

    // Values loaded into core while reset holds
    assign pc_reset_value           = '0;  // [RULE15]
    assign port_data_reset_value    = '1;  // [RULE16]
    assign port_control_reset_value = '1;  // [RULE16]

    // Read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (access && !hwrite) begin
            case ({haddr[7:2], 2'b00})
                reset_source_pkg::guard_code_addr:
                    hrdata <= {24'h0, guard_code_reg};
                reset_source_pkg::cause_flags_addr:
                    hrdata <= {28'h0, flags_reg}; // [RULE5]
                reset_source_pkg::level_select_addr:
                    hrdata <= {24'h0, level_code_reg};
                reset_source_pkg::control_addr:
                    hrdata <= {31'h0, powerdown_reg};
                reset_source_pkg::status_addr:
                    hrdata <= {30'h0, state_reg == st_delay,
                               system_reset};
                default:
                    hrdata <= 32'h0;
            endcase
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

endmodule

// File: verification/reset_source_control_sva.sv
`timescale 1ns/100ps
module reset_source_control_sva #(
    parameter int power_on_delay_cycles = 20,
    parameter int pc_width              = 13,
    parameter int port_width            = 8
) (
    // Clock and reset
    input wire logic                  hclk,
    input wire logic                  hresetn,
    // Bus
    input wire logic                  hsel,
    input wire logic [7:0]            haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic [31:0]           hwdata,
    input wire logic                  hready,
    input wire logic [31:0]           hrdata,
    // Sources and outputs
    input wire logic                  low_supply,
    input wire logic                  low_supply_qualified,
    input wire logic                  system_reset,
    input wire logic [1:0]            undervoltage_level,
    input wire logic [pc_width-1:0]   pc_reset_value,
    input wire logic [port_width-1:0] port_data_reset_value,
    input wire logic [port_width-1:0] port_control_reset_value
);
    logic        take;
    logic        rd_flags_q;
    logic        wr_ctl_q;
    logic        pd_q;
    logic [31:0] high_cnt;

    assign take = hsel && hready && htrans[1];

    // Snooped bus phases
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_flags_q <= 1'b0;
            wr_ctl_q   <= 1'b0;
        end else begin
            rd_flags_q <= take && !hwrite
                && haddr == reset_source_pkg::cause_flags_addr;
            wr_ctl_q   <= take && hwrite
                && haddr == reset_source_pkg::control_addr;
        end
    end

    // Power-down copy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) pd_q <= 1'b0;
        else if (wr_ctl_q) pd_q <= hwdata[0];
    end

    // Length of reset pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) high_cnt <= 32'h0;
        else if (system_reset) high_cnt <= high_cnt + 32'h1;
        else high_cnt <= 32'h0;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_PC_ZERO: assert property (pc_reset_value == '0)
        else $error("start address not zero");
    AST_PORT_ONES: assert property (&port_data_reset_value
        && &port_control_reset_value) else $error("port value not ones");
    AST_FLAGS_UPPER: assert property (rd_flags_q |->
        hrdata[31:4] == 28'h0) else $error("flag upper bits set");
    AST_UV_RESET: assert property (
        (low_supply && low_supply_qualified && !pd_q)[*8] |-> system_reset)
        else $error("low supply gave no reset");
    AST_PD_BLOCK: assert property (
        (pd_q && !system_reset)[*2] |=> !system_reset)
        else $error("reset in power-down");
    AST_DELAY: assert property ($fell(system_reset) |->
        high_cnt >= power_on_delay_cycles) else $error("delay too short");
    AST_START_HELD: assert property ($rose(hresetn) |->
        system_reset[*8]) else $error("reset not held");
    AST_LEVEL_POR: assert property ($rose(hresetn) |->
        undervoltage_level == reset_source_pkg::level_2v10)
        else $error("level not at power-on value");
endmodule

bind reset_source_control reset_source_control_sva #(
    .power_on_delay_cycles(power_on_delay_cycles), .pc_width(pc_width),
    .port_width(port_width)
) u_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .low_supply(low_supply),
    .low_supply_qualified(low_supply_qualified),
    .system_reset(system_reset), .undervoltage_level(undervoltage_level),
    .pc_reset_value(pc_reset_value),
    .port_data_reset_value(port_data_reset_value),
    .port_control_reset_value(port_control_reset_value)
);

// File: verification/reset_source_control_tb.sv
`timescale 1ns/100ps
module reset_source_control_tb;
    localparam int         delay_cycles = 20;
    localparam int         slow_half    = 8;
    localparam logic [7:0] flags        = reset_source_pkg::cause_flags_addr;
    localparam logic [7:0] level        = reset_source_pkg::level_select_addr;
    localparam logic [7:0] guard        = reset_source_pkg::guard_code_addr;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        slow_clk;
    logic        low;
    logic        low_q;
    logic        wd_fault;
    logic        sys_rst;
    logic [1:0]  uv_level;
    logic [12:0] pc_val;
    logic [7:0]  pdata;
    logic [7:0]  pctl;
    logic [31:0] rd;
    logic [31:0] seed;
    logic [7:0]  code;
    logic [7:0]  codes [4] = '{8'h55, 8'h33, 8'h99, 8'haa};
    int          fail_count;
    int          n_compared;
    int          cycles;
    int          wait_n;

    reset_source_control #(.power_on_delay_cycles(delay_cycles)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .slow_rc_clock(slow_clk), .low_supply(low),
        .low_supply_qualified(low_q), .watchdog_code_fault(wd_fault),
        .system_reset(sys_rst), .undervoltage_level(uv_level),
        .pc_reset_value(pc_val), .port_data_reset_value(pdata),
        .port_control_reset_value(pctl)
    );

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    // Slow clock and run limit
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles % slow_half == 0) slow_clk <= ~slow_clk;
        if (cycles == 5000) begin
            fail_count = fail_count + 1;
            print_verdict();
        end
    end

    function automatic logic [31:0] next_rand(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [1:0] level_of(input logic [7:0] c);
        case (c)
            8'h33:   return reset_source_pkg::level_2v55;
            8'h99:   return reset_source_pkg::level_3v15;
            8'haa:   return reset_source_pkg::level_3v80;
            default: return reset_source_pkg::level_2v10;
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wait_sr(input logic v, input int lim);
        wait_n = 0;
        while (sys_rst !== v && wait_n < lim) begin
            @(posedge hclk);
            wait_n++;
        end
    endtask

    task automatic code_fault(input logic [7:0] a);
        do seed = next_rand(seed); while (seed[7:0] inside {codes});
        xfer(a, 1'b1, {24'h0, seed[7:0]});
        wait_sr(1'b1, 100);
        // Two to three slow periods plus synchroniser latency
        check(wait_n > 4*slow_half && wait_n <= 6*slow_half + 6,
              1'b1);
        wait_sr(1'b0, 200);
        xfer(a, 1'b0, 32'h0);
        check(rd, 32'h55);
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
        {slow_clk, low, low_q, wd_fault} = '0;
        hsize = 3'b010;
        fail_count = 0;
        n_compared = 0;
        cycles = 0;
        seed = 32'hb6f9;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        wait_sr(1'b0, 100);
        check(wait_n >= delay_cycles, 1'b1);
        check(pc_val, 13'h0);
        check({pdata, pctl}, 16'hffff);
        xfer(guard, 1'b0, 32'h0);
        check(rd, 32'h55);
        xfer(level, 1'b0, 32'h0);
        check(rd, 32'h55);
        xfer(flags, 1'b0, 32'h0);
        check(rd & 32'hfffffffb, 32'h0);
        xfer(8'h20, 1'b1, 32'hffffffff);
        xfer(8'h20, 1'b0, 32'h0);
        check(rd, 32'h0);
        for (int i = 0; i < 8; i++) begin
            seed = next_rand(seed);
            code = codes[seed[1:0]];
            xfer(level, 1'b1, {24'h0, code});
            xfer(guard, 1'b1, seed[2] ? 32'haa : 32'h55);
            @(posedge hclk);
            check(uv_level, level_of(code));
        end
        repeat (6*slow_half) @(posedge hclk);
        check(sys_rst, 1'b0);
        code_fault(guard);
        xfer(flags, 1'b1, 32'hff);
        xfer(flags, 1'b0, 32'h0);
        check(rd & 32'hfffffffb, 32'h8);
        code_fault(level);
        check(uv_level, reset_source_pkg::level_2v10);
        xfer(flags, 1'b0, 32'h0);
        check(rd & 32'hfffffffb, 32'ha);
        xfer(flags, 1'b1, 32'h0);
        xfer(flags, 1'b0, 32'h0);
        check(rd, 32'h0);
        xfer(level, 1'b1, 32'h99);
        low <= 1'b1;
        repeat (40) @(posedge hclk);
        check(sys_rst, 1'b0);
        xfer(reset_source_pkg::control_addr, 1'b1, 32'h1);
        low_q <= 1'b1;
        repeat (40) @(posedge hclk);
        check(sys_rst, 1'b0);
        xfer(reset_source_pkg::control_addr, 1'b1, 32'h0);
        wait_sr(1'b1, 20);
        check(sys_rst, 1'b1);
        {low, low_q} <= 2'b00;
        wait_sr(1'b0, 200);
        xfer(level, 1'b0, 32'h0);
        check(rd, 32'h99);
        wd_fault <= 1'b1;
        wait_sr(1'b1, 40);
        wd_fault <= 1'b0;
        // Status while the watchdog source still holds reset
        xfer(reset_source_pkg::status_addr, 1'b0, 32'h0);
        check(rd, 32'h1);
        wait_sr(1'b0, 200);
        xfer(flags, 1'b0, 32'h0);
        check(rd, 32'h5);
        print_verdict();
    end
endmodule
